// [hdl/pwa_pkg.sv]
// constants and carrier types of the potentiometer serial-bus slave
// assumes nothing beyond a systemverilog compiler
package pwa_pkg;
    // -------------------------------------------------------------------
    // identification and register map
    // -------------------------------------------------------------------
    localparam logic [4:0] ID_FIXED      = 5'h14;   // 10100
    localparam logic [7:0] WIPER_ADDR    = 8'h00;
    localparam logic [7:0] ACCESS_ADDR   = 8'h10;
    localparam logic [7:0] WIPER_RESET   = 8'h80;
    localparam logic [7:0] ACCESS_RESET  = 8'h40;
    localparam logic [7:0] ACCESS_MASK   = 8'h40;   // only bit 6 is kept
    // -------------------------------------------------------------------
    // counts
    // -------------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int         SYNC_STAGES   = 2;

    typedef enum logic [2:0] {
        PWA_IDLE  = 3'b000,
        PWA_ID    = 3'b001,
        PWA_ADDR  = 3'b010,
        PWA_WDATA = 3'b011,
        PWA_RDATA = 3'b100,
        PWA_RACK  = 3'b101
    } pwa_state_t;

    // sampled bus lines with their edge and condition events
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } pwa_bus_ev_t;
endpackage : pwa_pkg

// [hdl/pwa_line_sync.sv]
// two-stage synchroniser and event finder for the serial clock and data
// assumes both lines are asynchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module pwa_line_sync (
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    input  wire logic           i_scl,
    input  wire logic           i_sda,
    output var pwa_pkg::pwa_bus_ev_t o_ev
);
    logic [1:0] meta_ff, nxt_meta;
    logic [1:0] sync_ff, nxt_sync;
    logic [1:0] prev_ff, nxt_prev;

    always_comb begin
        nxt_meta = {i_scl, i_sda};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // lines idle high, so reset to high avoids a false start
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
            prev_ff <= 2'h3;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    always_comb begin
        o_ev.scl_rise = sync_ff[1] & ~prev_ff[1];
        o_ev.scl_fall = ~sync_ff[1] & prev_ff[1];
        o_ev.start    = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
        o_ev.stop     = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];
        o_ev.sda      = sync_ff[0];
    end
endmodule : pwa_line_sync
`default_nettype wire

// [hdl/pwa_slave.sv]
// serial-bus slave holding the wiper and access control registers
// assumes a bus master drives the clock line; data line is open drain
`timescale 1ns/10ps
`default_nettype none
module pwa_slave (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_address_select_high_pin,
    input  wire logic       i_address_select_low_pin,
    output logic            o_sda_out,
    output logic            o_sda_oe_n,
    output logic [7:0]      o_wiper,
    output logic            o_shutdown_n
);
    // -------------------------------------------------------------------
    // line sampling
    // -------------------------------------------------------------------
    pwa_pkg::pwa_bus_ev_t ev;
    logic [1:0]           pin_meta_ff, pin_sync_ff;

    pwa_line_sync u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_scl  (i_scl),
        .i_sda  (i_sda),
        .o_ev   (ev)
    );

    // address pins are straps from outside, synchronised like the bus
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
        end else begin
            pin_meta_ff <= {i_address_select_high_pin,
                            i_address_select_low_pin};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    function automatic logic id_match(input logic [7:0] b,
                                      input logic [1:0] pins);
        id_match = (b[7:3] == pwa_pkg::ID_FIXED) && (b[2:1] == pins);
    endfunction : id_match

    function automatic logic [7:0] reg_pick(input logic [7:0] a,
                                            input logic [7:0] w,
                                            input logic [7:0] c);
        if (a == pwa_pkg::ACCESS_ADDR)
            reg_pick = c;
        else if (a == pwa_pkg::WIPER_ADDR)
            reg_pick = w;
        else
            reg_pick = 8'h00;
    endfunction : reg_pick

    // -------------------------------------------------------------------
    // transaction state
    // -------------------------------------------------------------------
    pwa_pkg::pwa_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_ff, nxt_bit;
    logic       ack_ff, nxt_ack;      // in the ninth bit slot
    logic       ackok_ff, nxt_ackok;  // this ninth slot is acknowledged
    logic       addrok_ff, nxt_addrok;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] wiper_ff, nxt_wiper;
    logic [7:0] access_ff, nxt_access;
    logic       sda_ff, nxt_sda;

    always_comb begin
        nxt_state  = state_ff;
        nxt_shift  = shift_ff;
        nxt_bit    = bit_ff;
        nxt_ack    = ack_ff;
        nxt_ackok  = ackok_ff;
        nxt_addrok = addrok_ff;
        nxt_addr   = addr_ff;
        nxt_wiper  = wiper_ff;
        nxt_access = access_ff;
        nxt_sda    = sda_ff;
        if (ev.start) begin
            // repeated start keeps the address byte for the read
            nxt_state = pwa_pkg::PWA_ID;
            nxt_bit   = 4'h0;
            nxt_ack   = 1'b0;
            nxt_sda   = 1'b1;
        end else if (ev.stop) begin
            nxt_state = pwa_pkg::PWA_IDLE;
            nxt_ack   = 1'b0;
            nxt_sda   = 1'b1;
        end else if (state_ff != pwa_pkg::PWA_IDLE) begin
            if (ev.scl_rise) begin
                if (state_ff == pwa_pkg::PWA_RACK) begin
                    // master ack keeps reading, nack ends it
                    if (ev.sda) begin
                        nxt_state = pwa_pkg::PWA_IDLE;
                    end else begin
                        nxt_state = pwa_pkg::PWA_RDATA;
                    end
                end else if (!ack_ff && state_ff != pwa_pkg::PWA_RDATA) begin
                    // outside a read, the data line is shifted in msb first
                    nxt_shift = {shift_ff[6:0], ev.sda};
                    nxt_bit   = bit_ff + 4'h1;
                end else if (state_ff == pwa_pkg::PWA_WDATA) begin
                    // transfer on the ninth clock of the data byte
                    if (addr_ff == pwa_pkg::WIPER_ADDR)
                        nxt_wiper = shift_ff;
                    else if (addr_ff == pwa_pkg::ACCESS_ADDR)
                        nxt_access = shift_ff & pwa_pkg::ACCESS_MASK;
                    nxt_state = pwa_pkg::PWA_IDLE;
                end
            end else if (ev.scl_fall) begin
                if (state_ff == pwa_pkg::PWA_RDATA && !ack_ff) begin
                    // drive next bit msb first
                    if (bit_ff == pwa_pkg::BITS_PER_BYTE) begin
                        nxt_ack   = 1'b1;
                        nxt_sda   = 1'b1;
                        nxt_state = pwa_pkg::PWA_RACK;
                    end else begin
                        nxt_sda   = shift_ff[7];
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_bit   = bit_ff + 4'h1;
                    end
                end else if (state_ff == pwa_pkg::PWA_RACK) begin
                    nxt_sda = 1'b1;
                end else if (!ack_ff && bit_ff == pwa_pkg::BITS_PER_BYTE) begin
                    nxt_ack   = 1'b1;
                    nxt_ackok = 1'b1;
                    if (state_ff == pwa_pkg::PWA_ID)
                        nxt_ackok = id_match(shift_ff, pin_sync_ff);
                    else if (state_ff == pwa_pkg::PWA_RDATA)
                        nxt_ackok = 1'b0;
                    nxt_sda = ~nxt_ackok;
                end else if (ack_ff) begin
                    // end of ninth slot: advance
                    nxt_ack = 1'b0;
                    nxt_bit = 4'h0;
                    nxt_sda = 1'b1;
                    unique case (state_ff)
                        pwa_pkg::PWA_ID: begin
                            if (!ackok_ff)
                                nxt_state = pwa_pkg::PWA_IDLE;
                            else if (shift_ff[0] && addrok_ff) begin
                                nxt_state = pwa_pkg::PWA_RDATA;
                                nxt_shift = reg_pick(addr_ff, wiper_ff,
                                                     access_ff);
                                nxt_sda   = nxt_shift[7];
                                nxt_shift = {nxt_shift[6:0], 1'b0};
                                nxt_bit   = 4'h1;
                            end else if (shift_ff[0])
                                nxt_state = pwa_pkg::PWA_IDLE;
                            else begin
                                nxt_state  = pwa_pkg::PWA_ADDR;
                                nxt_addrok = 1'b0;
                            end
                        end
                        pwa_pkg::PWA_ADDR: begin
                            nxt_addr   = shift_ff;
                            nxt_addrok = 1'b1;
                            nxt_state  = pwa_pkg::PWA_WDATA;
                        end
                        pwa_pkg::PWA_WDATA: nxt_state = pwa_pkg::PWA_IDLE;
                        pwa_pkg::PWA_RDATA: nxt_state = pwa_pkg::PWA_RDATA;
                        pwa_pkg::PWA_RACK:  nxt_state = pwa_pkg::PWA_RACK;
                        pwa_pkg::PWA_IDLE:  nxt_state = pwa_pkg::PWA_IDLE;
                        default:            nxt_state = pwa_pkg::PWA_IDLE;
                    endcase
                end
            end
        end else if (ev.scl_fall) begin
            // standby: make sure the line is released after the last ack
            nxt_sda = 1'b1;
            nxt_ack = 1'b0;
        end
        // read data reload at the fall that ends an acknowledged ninth clock
        if (!ev.start && !ev.stop && ev.scl_fall &&
            state_ff == pwa_pkg::PWA_RDATA && ack_ff) begin
            nxt_shift = reg_pick(addr_ff, wiper_ff, access_ff);
            nxt_sda   = nxt_shift[7];
            nxt_shift = {nxt_shift[6:0], 1'b0};
            nxt_bit   = 4'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff  <= pwa_pkg::PWA_IDLE;
            shift_ff  <= 8'h00;
            bit_ff    <= 4'h0;
            ack_ff    <= 1'b0;
            ackok_ff  <= 1'b0;
            addrok_ff <= 1'b0;
            addr_ff   <= 8'h00;
            wiper_ff  <= pwa_pkg::WIPER_RESET;
            access_ff <= pwa_pkg::ACCESS_RESET;
            sda_ff    <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            shift_ff  <= nxt_shift;
            bit_ff    <= nxt_bit;
            ack_ff    <= nxt_ack;
            ackok_ff  <= nxt_ackok;
            addrok_ff <= nxt_addrok;
            addr_ff   <= nxt_addr;
            wiper_ff  <= nxt_wiper;
            access_ff <= nxt_access;
            sda_ff    <= nxt_sda;
        end
    end

    // open drain: only a low is ever driven
    always_comb begin
        o_sda_out    = 1'b0;
        o_sda_oe_n   = sda_ff;
        o_wiper      = wiper_ff;
        o_shutdown_n = access_ff[6];
    end
endmodule : pwa_slave
`default_nettype wire

// [tb/pwa_master_model.sv]
// bus master model: drives the serial clock and pulls the data line
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/10ps
`default_nettype none
module pwa_master_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_lo
);
    int lag = 0; // extra low cycles: a slow master
    initial begin
        o_scl    = 1'b1;
        o_sda_lo = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // data moves only while the clock is low; sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        tick(2);
        o_sda_lo <= ~b;
        tick(6 + lag);
        o_scl <= 1'b1;
        tick(5);
        r = i_sda;
        tick(3);
        o_scl <= 1'b0;
    endtask : bit_x
    task automatic start();
        tick(2);
        o_sda_lo <= 1'b0;
        tick(6);
        o_scl <= 1'b1;
        tick(8);
        o_sda_lo <= 1'b1;
        tick(8);
        o_scl <= 1'b0;
    endtask : start
    task automatic stop();
        tick(2);
        o_sda_lo <= 1'b1;
        tick(6);
        o_scl <= 1'b1;
        tick(8);
        o_sda_lo <= 1'b0;
        tick(8);
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : rbyte
endmodule : pwa_master_model
`default_nettype wire

// [tb/pwa_slave_sva.sv]
// checker on the slave's ports, bound below
// assumes the bench clock is i_clk with async active-low reset
`timescale 1ns/10ps
`default_nettype none
module pwa_slave_sva (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe_n,
    input wire logic [7:0] o_wiper,
    input wire logic       o_shutdown_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_rst;
        $rose(i_rstn) |-> o_wiper == 8'h80 && o_sda_oe_n && o_shutdown_n;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset values");
    property p_pull;
        !o_sda_oe_n |-> !o_sda_out && !i_sda;
    endproperty
    a_pull: assert property (p_pull) else $error("line not low");
    // data line may only move while the clock is low
    property p_oe_scl;
        $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2);
    endproperty
    a_oe_scl: assert property (p_oe_scl) else $error("drive edge");
    property p_ack_hold;
        $fell(o_sda_oe_n) |-> !o_sda_oe_n [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("short");
    property p_release;
        $fell(o_sda_oe_n) |-> ##[1:300] $rose(o_sda_oe_n);
    endproperty
    a_release: assert property (p_release) else $error("held");
    property p_wiper_ack;
        $changed(o_wiper) |-> !o_sda_oe_n && i_scl;
    endproperty
    a_wiper_ack: assert property (p_wiper_ack) else $error("no ack");
    property p_wiper_rise;
        $changed(o_wiper) |-> $past(i_scl, 2) && !$past(i_scl, 7);
    endproperty
    a_wiper_rise: assert property (p_wiper_rise) else $error("late");
    property p_shdn;
        $changed(o_shutdown_n) |-> !o_sda_oe_n && $past(i_scl, 2);
    endproperty
    a_shdn: assert property (p_shdn) else $error("access update");
    c_write: cover property ($changed(o_wiper));
    c_shdn: cover property ($fell(o_shutdown_n));
    c_drive: cover property ($fell(o_sda_oe_n) ##1 i_scl);
endmodule : pwa_slave_sva
bind pwa_slave pwa_slave_sva pwa_slave_sva_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .o_wiper(o_wiper), .o_shutdown_n(o_shutdown_n));
`default_nettype wire

// [tb/pot_wiper_i2c_register_access_tb_top.sv]
// bench: master model against the slave, with a register model
// assumes the data line has a pull-up; device pulls it when enabled
`timescale 1ns/10ps
`default_nettype none
module pot_wiper_i2c_register_access_tb_top;
    logic       i_clk  = 1'b0;
    logic       i_rstn = 1'b0;
    logic       pin_hi = 1'b0;
    logic       pin_lo = 1'b0;
    logic       scl, sda_lo, sda_out, oe_n, shdn_n;
    logic [7:0] wiper;
    wire  logic sda;
    int         fail_count = 0;
    int         n_checks   = 0;
    int         m_wiper    = 8'h80;
    int         m_acr      = 8'h40;
    always #5 i_clk = ~i_clk;
    assign sda = ~(sda_lo | (~oe_n & ~sda_out));
    pwa_master_model pwa_master_model_inst (.i_clk(i_clk), .i_sda(sda),
        .o_scl(scl), .o_sda_lo(sda_lo));
    pwa_slave pwa_slave_inst (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_scl(scl), .i_sda(sda), .i_address_select_high_pin(pin_hi),
        .i_address_select_low_pin(pin_lo), .o_sda_out(sda_out),
        .o_sda_oe_n(oe_n), .o_wiper(wiper), .o_shutdown_n(shdn_n));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    function automatic logic [7:0] m_rd(input logic [7:0] a);
        return a == 8'h00 ? m_wiper[7:0] : a == 8'h10 ? m_acr[7:0] : 8'h00;
    endfunction : m_rd
    task automatic wr(input logic [6:0] dv, input logic [7:0] a, d,
                      input logic ok);
        logic [2:0] k;
        pwa_master_model_inst.start();
        pwa_master_model_inst.wbyte({dv, 1'b0}, k[2]);
        pwa_master_model_inst.wbyte(a, k[1]);
        pwa_master_model_inst.wbyte(d, k[0]);
        pwa_master_model_inst.stop();
        chk("write acks", {5'h00, {3{ok}}}, {5'h00, k});
        if (ok && a == 8'h00) m_wiper = d;
        if (ok && a == 8'h10) m_acr = d & 8'h40;
        chk("wiper", m_wiper[7:0], wiper);
        chk("shutdown", {7'h00, m_acr[6]}, {7'h00, shdn_n});
    endtask : wr
    task automatic rd(input logic [6:0] dv, input logic [7:0] a);
        logic [2:0] k;
        logic [7:0] d;
        pwa_master_model_inst.start();
        pwa_master_model_inst.wbyte({dv, 1'b0}, k[2]);
        pwa_master_model_inst.wbyte(a, k[1]);
        pwa_master_model_inst.start();
        pwa_master_model_inst.wbyte({dv, 1'b1}, k[0]);
        chk("read acks", 8'h07, {5'h00, k});
        pwa_master_model_inst.rbyte(1'b0, d);
        chk("read data", m_rd(a), d);
        pwa_master_model_inst.rbyte(1'b1, d);
        chk("read data 2", m_rd(a), d);
        pwa_master_model_inst.stop();
        chk("released", 8'h01, {7'h00, oe_n});
    endtask : rd
    initial begin
        repeat (80000) @(posedge i_clk);
        fail_count++;
        summarize();
    end
    initial begin
        logic [7:0] a;
        logic [6:0] dv;
        void'($urandom(32'hbebd86a3));
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk("reset wiper", 8'h80, wiper);
        dv = {pwa_pkg::ID_FIXED, 2'b00};
        rd(dv, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(posedge i_clk);
            {pin_hi, pin_lo} <= 2'($urandom);
            pwa_master_model_inst.lag = (i % 2) * 10;
            @(posedge i_clk);
            dv = {pwa_pkg::ID_FIXED, pin_hi, pin_lo};
            a = i % 3 == 0 ? 8'h00 : i % 3 == 1 ? 8'h10 : 8'h20 | 8'($urandom % 16);
            wr(dv, a, 8'($urandom), 1'b1);
            rd(dv, a);
        end
        wr({pwa_pkg::ID_FIXED, ~pin_hi, pin_lo}, 8'h00, 8'h3c, 1'b0);
        wr({5'h15, pin_hi, pin_lo}, 8'h10, 8'h00, 1'b0);
        summarize();
    end
endmodule : pot_wiper_i2c_register_access_tb_top
`default_nettype wire
